/* File: rtl/cosdt_pkg.sv */
package cosdt_pkg;
    // counter and bus widths
    localparam int CNT_W = 16;
    localparam int ADR_W = 6;
    localparam int DT_W  = 10;

    // register byte offsets
    localparam logic [ADR_W-1:0] OFS_OEP  = 6'h00; // output_enable_polarity
    localparam logic [ADR_W-1:0] OFS_DTB  = 6'h04; // deadtime_break_control
    localparam logic [ADR_W-1:0] OFS_IDLE = 6'h08; // idle_level_config
    localparam logic [ADR_W-1:0] OFS_CTL  = 6'h0c; // timer_control_one
    localparam logic [ADR_W-1:0] OFS_ARR  = 6'h10; // period_reload_value
    localparam logic [ADR_W-1:0] OFS_CMP1 = 6'h14; // compare_value_ch1
    localparam logic [ADR_W-1:0] OFS_CMP2 = 6'h18; // compare_value_ch2
    localparam logic [ADR_W-1:0] OFS_WAVE = 6'h1c; // channel_wave_mode, both channels
    localparam logic [ADR_W-1:0] OFS_STAT = 6'h20; // counter and reference levels

    // writable bits and reset values
    localparam logic [31:0] OEP_MASK  = 32'h0033_bfff;
    localparam logic [15:0] IDLE_MASK = 16'h007f;
    localparam logic [15:0] CTL_MASK  = 16'h0370;
    localparam logic [31:0] RST_OEP   = 32'h0000_0000;
    localparam logic [15:0] RST_DTB   = 16'h0000;
    localparam logic [15:0] RST_IDLE  = 16'h0000;
    localparam logic [15:0] RST_CTL   = 16'h0000;
    localparam logic [15:0] RST_CNT   = 16'h0000;

    // field positions
    localparam int CFG_STRIDE = 4;   // enable/polarity nibble per channel
    localparam int CKD_LSB    = 8;   // dead_clock_divider [9:8]
    localparam int CMS_LSB    = 5;   // center_align_select [6:5]
    localparam int DIR_BIT    = 4;   // count direction
    localparam int GATE_BIT   = 15;  // main_output_gate
    localparam int WAVE2_LSB  = 8;   // channel 2 wave mode [11:8]
    localparam int IDLE_P1    = 0;
    localparam int IDLE_C1    = 1;
    localparam int IDLE_P2    = 2;

    // dead-time formula bases
    localparam logic [DT_W-1:0] DT_BASE64 = 10'h040;
    localparam logic [DT_W-1:0] DT_BASE32 = 10'h020;

    // dead-time tick divider codes
    localparam logic [1:0] CKD_DIV1 = 2'h0;
    localparam logic [1:0] CKD_DIV2 = 2'h1;
    localparam logic [1:0] CKD_DIV4 = 2'h2;

    typedef enum logic [3:0] {
        WM_FROZEN   = 4'b0000,
        WM_SET      = 4'b0001,
        WM_CLEAR    = 4'b0010,
        WM_TOGGLE   = 4'b0011,
        WM_LOW      = 4'b0100,
        WM_HIGH     = 4'b0101,
        WM_PWM1     = 4'b0110,
        WM_PWM2     = 4'b0111
    } cosdt_wave_t;

    // one channel nibble, low bit first: pen, ppol, cen, cpol
    typedef struct packed {
        logic cpol;
        logic cen;
        logic ppol;
        logic pen;
    } cosdt_chcfg_t;

    // register port request
    typedef struct packed {
        logic [ADR_W-1:0] addr;
        logic [31:0]      wdata;
        logic             wr;
        logic             rd;
    } cosdt_bus_t;
endpackage : cosdt_pkg

/* File: rtl/cosdt_top.sv */
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/100ps
// How it works
// - counter is 16 bits, edge aligned, counting upward only
// - channel 1 has primary and complementary outputs, dead time, own polarity
// - channel 2 has one primary output with polarity, no dead time
// - polarity bit 0 means active high, 1 means active low
// - primary enable alone: primary follows reference; neither: both take idle levels
// - complementary enable alone: complementary follows reference
// - both enables set: complementary pair with dead time
// - every edge of either output to its active level is delayed by dead time
// - code bit 7 clear: dead time is code times one tick
// - code top bits 10: (64 plus low six bits) times two ticks
// - code 110 or 111: (32 plus low five bits) times eight or sixteen
// - divider field gives tick of one, two or four clocks
// - two-channel variant drives both primaries, one complementary, both matches
// - one-channel variant drives channel 1 outputs, its match and update
// - disabled output takes its idle-level bit, 0 low, 1 high
// - idle-level bits in order ch1 p, ch1 c, ch2 p, upward
// - enable/polarity word: four bits per channel, ch5 and ch6 at 16, 20
// - wave mode sets reference: set, clear, toggle on match, two PWMs
// - realign rising edge clears counter and loads pending settings
// - match and update events are single pulses
module cosdt_top
    import cosdt_pkg::*;
#(
    parameter int NUM_CH = 2
) (
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire cosdt_bus_t        bus,
    output logic [31:0]            rdata,
    input  wire logic              realign,
    output logic [1:0]             primary_output,
    output logic                   complementary_output,
    output logic [1:0]             compare_match_pulse,
    output logic                   update_event_pulse
);

    // software registers
    logic [31:0]      oep;
    logic [15:0]      dtb;
    logic [15:0]      idle;
    logic [15:0]      ctl;
    logic [CNT_W-1:0] arr_pend;
    logic [CNT_W-1:0] cmp_pend [2];
    logic [3:0]       wave_pend [2];

    // live copies used by the counter
    logic [CNT_W-1:0] arr_act;
    logic [CNT_W-1:0] cmp_act [2];
    logic [3:0]       wave_act [2];

    logic [CNT_W-1:0] cnt;
    logic [1:0]       ref_wave;
    logic             ref_prev;
    logic [DT_W-1:0]  dt_cnt;
    logic [1:0]       div_cnt;
    logic             sync_ff1;
    logic             sync_ff2;
    logic             sync_ff3;

    cosdt_chcfg_t     cfg1;
    cosdt_chcfg_t     cfg2;
    logic             upd;
    logic             sync_rise;
    logic             load_act;
    logic [1:0]       match;
    logic [1:0]       below;
    logic [1:0]       dead_clock_divider;
    logic             tick;
    logic [DT_W-1:0]  dt_ticks;
    logic             ref_edge;
    logic             dt_done;
    logic             p1_dt;
    logic             c1_dt;
    logic             p1_lvl;
    logic             c1_lvl;
    logic             p2_lvl;
    logic             next_p1;
    logic             next_c1;
    logic             next_p2;
    logic [31:0]      next_rdata;

    assign cfg1 = cosdt_chcfg_t'(oep[CFG_STRIDE-1:0]);
    assign cfg2 = cosdt_chcfg_t'(oep[2*CFG_STRIDE-1:CFG_STRIDE]);
    assign dead_clock_divider  = ctl[CKD_LSB+1:CKD_LSB];

    // register writes; the wide word keeps only implemented bit positions
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            oep          <= RST_OEP;
            dtb          <= RST_DTB;
            idle         <= RST_IDLE;
            ctl          <= RST_CTL;
            arr_pend     <= RST_CNT;
            cmp_pend[0]  <= RST_CNT;
            cmp_pend[1]  <= RST_CNT;
            wave_pend[0] <= WM_FROZEN;
            wave_pend[1] <= WM_FROZEN;
        end else if (bus.wr) begin
            unique case (bus.addr)
                // stored as laid out, ch5/ch6 included
                OFS_OEP:  oep <= bus.wdata & OEP_MASK;
                // gate bit stored only, outputs always gated on
                OFS_DTB:  dtb <= bus.wdata[15:0];
                OFS_IDLE: idle <= bus.wdata[15:0] & IDLE_MASK;
                // other align and direction codes are not honoured
                OFS_CTL:  ctl <= bus.wdata[15:0] & CTL_MASK;
                OFS_ARR:  arr_pend <= bus.wdata[CNT_W-1:0];
                OFS_CMP1: cmp_pend[0] <= bus.wdata[CNT_W-1:0];
                OFS_CMP2: cmp_pend[1] <= bus.wdata[CNT_W-1:0];
                OFS_WAVE: begin
                    wave_pend[0] <= bus.wdata[3:0];
                    wave_pend[1] <= bus.wdata[WAVE2_LSB+3:WAVE2_LSB];
                end
                default: ;
            endcase
        end
    end

    // read data stands only in the cycle after the strobe
    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (bus.addr)
            OFS_OEP:  next_rdata = oep;
            OFS_DTB:  next_rdata = {16'h0000, dtb};
            OFS_IDLE: next_rdata = {16'h0000, idle};
            OFS_CTL:  next_rdata = {16'h0000, ctl};
            OFS_ARR:  next_rdata = {16'h0000, arr_pend};
            OFS_CMP1: next_rdata = {16'h0000, cmp_pend[0]};
            OFS_CMP2: next_rdata = {16'h0000, cmp_pend[1]};
            OFS_WAVE: next_rdata = {20'h00000, wave_pend[1], 4'h0, wave_pend[0]};
            OFS_STAT: next_rdata = {14'h0000, ref_wave, cnt};
            default:  next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= 32'h0000_0000;
        end else begin
            rdata <= bus.rd ? next_rdata : 32'h0000_0000;
        end
    end

    // realign pin: two stages, then a third for the edge
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync_ff1 <= 1'b0;
            sync_ff2 <= 1'b0;
            sync_ff3 <= 1'b0;
        end else begin
            sync_ff1 <= realign;
            sync_ff2 <= sync_ff1;
            sync_ff3 <= sync_ff2;
        end
    end

    assign sync_rise = sync_ff2 & ~sync_ff3;
    assign upd       = (cnt == arr_act);
    assign load_act  = upd | sync_rise;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= RST_CNT;
        end else if (load_act) begin
            cnt <= RST_CNT;
        end else begin
            cnt <= cnt + 16'h0001;
        end
    end

    // pending settings go live on update or realign
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            arr_act     <= RST_CNT;
            cmp_act[0]  <= RST_CNT;
            cmp_act[1]  <= RST_CNT;
            wave_act[0] <= WM_FROZEN;
            wave_act[1] <= WM_FROZEN;
        end else if (load_act) begin
            arr_act     <= arr_pend;
            cmp_act[0]  <= cmp_pend[0];
            cmp_act[1]  <= cmp_pend[1];
            wave_act[0] <= wave_pend[0];
            wave_act[1] <= wave_pend[1];
        end
    end

    for (genvar i = 0; i < 2; i++) begin : g_ref
        assign match[i] = (cnt == cmp_act[i]);
        assign below[i] = (cnt < cmp_act[i]);
        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                ref_wave[i] <= 1'b0;
            end else begin
                unique case (wave_act[i])
                    WM_SET:    ref_wave[i] <= ref_wave[i] | match[i];
                    WM_CLEAR:  ref_wave[i] <= ref_wave[i] & ~match[i];
                    WM_TOGGLE: ref_wave[i] <= ref_wave[i] ^ match[i];
                    WM_LOW:    ref_wave[i] <= 1'b0;
                    WM_HIGH:   ref_wave[i] <= 1'b1;
                    WM_PWM1:   ref_wave[i] <= below[i];
                    WM_PWM2:   ref_wave[i] <= ~below[i];
                    default:   ref_wave[i] <= ref_wave[i]; // frozen, unsupported
                endcase
            end
        end
    end

    // channel 2 match stays low in the one-channel build
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            compare_match_pulse <= 2'b00;
            update_event_pulse  <= 1'b0;
        end else begin
            compare_match_pulse[0] <= match[0];
            compare_match_pulse[1] <= (NUM_CH > 1) & match[1];
            update_event_pulse     <= upd;
        end
    end

    // tick every one, two or four clocks; code 11 behaves as 00
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            div_cnt <= 2'b00;
        end else begin
            div_cnt <= div_cnt + 2'b01;
        end
    end

    assign tick = (dead_clock_divider == CKD_DIV2) ? div_cnt[0] :
                  (dead_clock_divider == CKD_DIV4) ? (div_cnt == 2'b11) : 1'b1;

    // dead time in ticks
    always_comb begin
        if (!dtb[7]) begin
            dt_ticks = {2'b00, dtb[7:0]};
        end else if (!dtb[6]) begin
            dt_ticks = (DT_BASE64 + {4'h0, dtb[5:0]}) << 1;
        end else if (!dtb[5]) begin
            dt_ticks = (DT_BASE32 + {5'h00, dtb[4:0]}) << 3;
        end else begin
            dt_ticks = (DT_BASE32 + {5'h00, dtb[4:0]}) << 4;
        end
    end

    // any reference edge restarts the wait; load is one short of the
    // count when a tick falls in the edge cycle, which is then the first waited tick
    // a short pulse restarts it again, so the delayed side never fires
    assign ref_edge = ref_wave[0] ^ ref_prev;
    assign dt_done  = ref_edge ? (dt_ticks == 10'h000) : (dt_cnt == 10'h000);
    assign p1_dt    = ref_wave[0] & dt_done;
    assign c1_dt    = ~ref_wave[0] & dt_done;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ref_prev <= 1'b0;
            dt_cnt   <= 10'h000;
        end else begin
            ref_prev <= ref_wave[0];
            // the edge cycle counts as a waited tick only when a tick falls in it;
            // with a slow tick the wait would otherwise end up to one tick early
            // and the delayed edge would come before the programmed dead time
            // trade-off: the first tick may be partial, so the wait can run short
            // by at most one divider period less one clock
            if (ref_edge) begin
                dt_cnt <= (dt_ticks == 10'h000) ? 10'h000 : dt_ticks - {9'h000, tick};
            end else if (tick && dt_cnt != 10'h000) begin
                dt_cnt <= dt_cnt - 10'h001;
            end
        end
    end

    // levels after polarity, before idle handling
    assign p1_lvl = (cfg1.cen ? p1_dt : ref_wave[0]) ^ cfg1.ppol;
    assign c1_lvl = (cfg1.pen ? c1_dt : ref_wave[0]) ^ cfg1.cpol;
    assign p2_lvl = ref_wave[1] ^ cfg2.ppol;

    // polarity applied above, disabled outputs take idle level
    // a cleared enable selects the idle bit
    always_comb begin
        next_p1 = cfg1.pen ? p1_lvl : idle[IDLE_P1];
        next_c1 = cfg1.cen ? c1_lvl : idle[IDLE_C1];
        next_p2 = cfg2.pen ? p2_lvl : idle[IDLE_P2];
    end

    // enable word reaches the pins one cycle later
    // second primary only in the two-channel build
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            primary_output       <= 2'b00;
            complementary_output <= 1'b0;
        end else begin
            primary_output[0]    <= next_p1;
            primary_output[1]    <= (NUM_CH > 1) & next_p2;
            complementary_output <= next_c1;
        end
    end

    // checks on the design's own behaviour
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    AST_CNT_STEP: assert property (
        !load_act |=> cnt == $past(cnt) + 16'h0001)
        else $error("counter did not step up by one");

    AST_CNT_WRAP: assert property (
        upd |=> cnt == 16'h0000 && update_event_pulse)
        else $error("period end did not clear counter with update pulse");

    AST_REALIGN: assert property (
        $rose(sync_ff2) |=> cnt == 16'h0000)
        else $error("realign edge did not clear counter");

    AST_MATCH_PULSE: assert property (
        match[0] && !upd |=> compare_match_pulse[0] ##1 !compare_match_pulse[0])
        else $error("match pulse not a single cycle");

    AST_P1_ONLY: assert property (
        cfg1.pen && !cfg1.cen |=> primary_output[0] == $past(p1_lvl)
            && complementary_output == $past(idle[IDLE_C1]))
        else $error("primary-only mode wrong");

    AST_C1_ONLY: assert property (
        cfg1.cen && !cfg1.pen |=> complementary_output == ($past(ref_wave[0])
            ^ $past(cfg1.cpol)))
        else $error("complementary-only mode wrong");

    AST_IDLE: assert property (
        !cfg1.pen |=> primary_output[0] == $past(idle[IDLE_P1]))
        else $error("disabled output not at idle level");

    AST_NO_OVERLAP: assert property (
        cfg1.pen && cfg1.cen && !cfg1.ppol && !cfg1.cpol
            |=> !(primary_output[0] && complementary_output))
        else $error("pair active together");

    AST_DT_HOLD: assert property (
        cfg1.pen && cfg1.cen && !cfg1.ppol && ref_edge && ref_wave[0]
            && dead_clock_divider == CKD_DIV1 && dt_ticks == 10'h003
            |=> !primary_output[0] [*3] ##1 primary_output[0] || ref_edge)
        else $error("dead time of three ticks not kept");

    AST_DT_ZERO: assert property (
        cfg1.pen && cfg1.cen && !cfg1.ppol && ref_edge && ref_wave[0]
            && dt_ticks == 10'h000 |=> primary_output[0])
        else $error("zero dead time delayed the edge");

    AST_CH2: assert property (
        NUM_CH > 1 && cfg2.pen |=> primary_output[1] == $past(p2_lvl))
        else $error("channel 2 output wrong");

    COV_PAIR: cover property (cfg1.pen && cfg1.cen && ref_edge);
    COV_REALIGN: cover property (sync_rise);
    COV_SHORT: cover property (ref_edge ##1 ref_edge);
    COV_WRAP: cover property (upd && !sync_rise);

endmodule : cosdt_top

/* File: sim/cosdt_gate_driver.sv */
`timescale 1ns/100ps
// gate driver pair of one half bridge, high side on the primary pin
module cosdt_gate_driver (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        clr,
    input  wire logic        hi_gate,
    input  wire logic        lo_gate,
    output logic [15:0]      overlap
);
    // shoot-through count
    // both switches on at once would short the rail, so every such cycle is counted
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            overlap <= 16'h0000;
        end else if (clr) begin
            overlap <= 16'h0000;
        end else if (hi_gate && lo_gate) begin
            overlap <= overlap + 16'h0001;
        end
    end
endmodule : cosdt_gate_driver

/* File: sim/tb_cosdt_top.sv */
`timescale 1ns/100ps
module tb_cosdt_top
    import cosdt_pkg::*;
;
    typedef struct packed {
        logic [2:0]  sel;
        logic [31:0] lo;
        logic [31:0] hi;
    } cosdt_exp_t;

    logic        clk, rst_b, realign, clr, samp, rd_d, complementary_output, update_event_pulse;
    cosdt_bus_t  bus;
    logic [31:0] rdata, w_p, w_c, cur_p, cur_c, n_upd, n_m0, n_m1;
    logic [1:0]  primary_output, compare_match_pulse, r;
    logic [15:0] overlap;
    logic [3:0]  n2;
    logic [6:0]  idle;
    cosdt_exp_t  exp_q[$];
    int          err_count, samples_checked;
    integer      seed;
    // dead-time table: code, divider, expected length in clocks, divider ratio
    logic [7:0]  dt_code [6] = '{8'h05, 8'h81, 8'hc1, 8'he0, 8'h05, 8'h05};
    logic [1:0]  dt_ckd  [6] = '{CKD_DIV1, CKD_DIV1, CKD_DIV1, CKD_DIV1, CKD_DIV2, CKD_DIV4};
    int          dt_len  [6] = '{5, 130, 264, 512, 10, 20};
    int          dt_div  [6] = '{1, 1, 1, 1, 2, 4};

    cosdt_top #(.NUM_CH(2)) cosdt_top_inst (
        .clk(clk), .rst_b(rst_b), .bus(bus), .rdata(rdata), .realign(realign),
        .primary_output(primary_output), .complementary_output(complementary_output),
        .compare_match_pulse(compare_match_pulse), .update_event_pulse(update_event_pulse)
    );

    cosdt_gate_driver cosdt_gate_driver_inst (
        .clk(clk), .rst_b(rst_b), .clr(clr), .hi_gate(primary_output[0]),
        .lo_gate(complementary_output), .overlap(overlap)
    );

    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // pulse widths and event counts, restarted by clr
    always @(posedge clk) begin
        if (clr) begin
            {w_p, w_c, cur_p, cur_c, n_upd, n_m0, n_m1} <= '0;
        end else begin
            cur_p <= primary_output[0] ? cur_p + 32'h1 : 32'h0;
            cur_c <= complementary_output ? cur_c + 32'h1 : 32'h0;
            if (!primary_output[0] && cur_p != 32'h0) w_p <= cur_p;
            if (!complementary_output && cur_c != 32'h0) w_c <= cur_c;
            n_upd <= n_upd + {31'h0, update_event_pulse};
            n_m0  <= n_m0 + {31'h0, compare_match_pulse[0]};
            n_m1  <= n_m1 + {31'h0, compare_match_pulse[1]};
        end
    end

    function automatic logic [31:0] get_meas(input logic [2:0] s);
        case (s)
            3'd0: return w_p;
            3'd1: return w_c;
            3'd2: return n_upd;
            3'd3: return n_m0;
            3'd4: return n_m1;
            3'd5: return {16'h0, overlap};
            default: return {29'h0, primary_output[1], complementary_output, primary_output[0]};
        endcase
    endfunction : get_meas

    // steady pin levels from enables, polarities, idle bits and references
    function automatic logic [31:0] pins_exp(input cosdt_chcfg_t c1, input cosdt_chcfg_t c2,
                                             input logic [2:0] il, input logic [1:0] rf);
        logic p1, n1, p2;
        p1 = c1.pen ? (rf[0] ^ c1.ppol) : il[IDLE_P1];
        n1 = c1.cen ? ((c1.pen ? !rf[0] : rf[0]) ^ c1.cpol) : il[IDLE_C1];
        p2 = c2.pen ? (rf[1] ^ c2.ppol) : il[IDLE_P2];
        return {29'h0, p2, n1, p1};
    endfunction : pins_exp

    task automatic compare(input logic [31:0] v);
        cosdt_exp_t e;
        e = exp_q.pop_front();
        samples_checked++;
        if ((v >= e.lo && v <= e.hi) !== 1'b1) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, v, e.lo, e.hi);
        end
    endtask : compare

    // results: read data one cycle after the strobe, measurements on request
    always @(posedge clk) begin
        if (rd_d) compare(rdata);
        if (samp) compare(get_meas(exp_q[0].sel));
        rd_d <= bus.rd;
    end

    // one access, then a release cycle so strobes never repeat
    task automatic bus_op(input logic [ADR_W-1:0] a, input logic [31:0] d, input logic w);
        bus <= '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge clk);
        bus.wr <= 1'b0;
        bus.rd <= 1'b0;
        @(posedge clk);
    endtask : bus_op

    task automatic wr_reg(input logic [ADR_W-1:0] a, input logic [31:0] d);
        bus_op(a, d, 1'b1);
    endtask : wr_reg

    task automatic rd_reg(input logic [ADR_W-1:0] a, input logic [31:0] lo, input logic [31:0] hi);
        exp_q.push_back('{3'd7, lo, hi});
        bus_op(a, 32'h0, 1'b0);
    endtask : rd_reg

    task automatic chk(input logic [2:0] s, input logic [31:0] lo, input logic [31:0] hi);
        @(posedge clk);
        exp_q.push_back('{s, lo, hi});
        samp <= 1'b1;
        @(posedge clk);
        samp <= 1'b0;
    endtask : chk

    task automatic clear();
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
    endtask : clear

    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run

    // watchdog well beyond the roughly 35300 cycles the tests need
    initial begin
        #(60000 * 20);
        err_count++;
        complete_run();
    end

    // main sequence
    initial begin
        seed = 96;
        {rst_b, realign, clr, samp} = '0;
        bus = '0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rd_reg(OFS_OEP, RST_OEP, RST_OEP);
        rd_reg(OFS_DTB, {16'h0, RST_DTB}, {16'h0, RST_DTB});
        rd_reg(OFS_IDLE, {16'h0, RST_IDLE}, {16'h0, RST_IDLE});
        rd_reg(OFS_CTL, {16'h0, RST_CTL}, {16'h0, RST_CTL});
        wr_reg(6'h3c, 32'hffff_ffff);
        rd_reg(6'h3c, 32'h0, 32'h0);
        wr_reg(OFS_OEP, 32'hffff_ffff);
        rd_reg(OFS_OEP, OEP_MASK, OEP_MASK);
        wr_reg(OFS_IDLE, 32'hffff_ffff);
        rd_reg(OFS_IDLE, {16'h0, IDLE_MASK}, {16'h0, IDLE_MASK});
        wr_reg(OFS_DTB, 32'h0000_8000);
        wr_reg(OFS_CTL, 32'h0);
        $display("test registers done");
        // every ch1 enable/polarity nibble, random ch2 nibble, idle bits and references
        for (int i = 0; i < 16; i++) begin
            n2 = $random(seed);
            idle = $random(seed);
            r = $random(seed);
            wr_reg(OFS_WAVE, {20'h0, r[1] ? WM_HIGH : WM_LOW, 4'h0, r[0] ? WM_HIGH : WM_LOW});
            wr_reg(OFS_IDLE, {25'h0, idle});
            wr_reg(OFS_OEP, {24'h0, n2, i[3:0]});
            repeat (4) @(posedge clk);
            chk(3'd6, pins_exp(i[3:0], n2, idle[2:0], r), pins_exp(i[3:0], n2, idle[2:0], r));
        end
        $display("test polarity and idle done");
        wr_reg(OFS_ARR, 32'd1199);
        wr_reg(OFS_CMP1, 32'd600);
        wr_reg(OFS_CMP2, 32'd0);
        wr_reg(OFS_IDLE, 32'h0);
        wr_reg(OFS_OEP, 32'h0000_0015);
        for (int k = 0; k < 6; k++) begin
            wr_reg(OFS_CTL, {22'h0, dt_ckd[k], 8'h00});
            wr_reg(OFS_DTB, {16'h0, 8'h80, dt_code[k]});
            wr_reg(OFS_WAVE, {20'h0, WM_PWM1, 4'h0, k[0] ? WM_PWM2 : WM_PWM1});
            repeat (2400) @(posedge clk);
            clear();
            repeat (2399) @(posedge clk);
            chk(3'd2, 32'd2, 32'd2);
            chk(3'd3, 32'd2, 32'd3);
            chk(3'd4, 32'd2, 32'd3);
            chk(3'd0, 600 - dt_len[k], 600 - dt_len[k] + dt_div[k] - 1);
            chk(3'd1, 600 - dt_len[k], 600 - dt_len[k] + dt_div[k] - 1);
            chk(3'd5, 32'd0, 32'd0);
            $display("test dead time %0d done", k);
        end
        // reference pulse of 3 clocks against a dead time of 5
        wr_reg(OFS_WAVE, {20'h0, WM_PWM1, 4'h0, WM_PWM1});
        wr_reg(OFS_CMP1, 32'd3);
        wr_reg(OFS_CTL, 32'h0);
        wr_reg(OFS_DTB, 32'h0000_8005);
        repeat (2400) @(posedge clk);
        clear();
        repeat (2399) @(posedge clk);
        chk(3'd0, 32'd0, 32'd0);
        chk(3'd1, 32'd1192, 32'd1192);
        $display("test short pulse done");
        // references held low so the status word shows only the counter
        wr_reg(OFS_WAVE, 32'h0000_0404);
        repeat (1300) @(posedge clk);
        realign <= 1'b1;
        repeat (7) @(posedge clk);
        rd_reg(OFS_STAT, 32'd1, 32'd6);
        realign <= 1'b0;
        $display("test realign done");
        complete_run();
    end
endmodule : tb_cosdt_top
